/* File: common/ssl_pkg.sv */
// Shared constants for the switcher serial control link.
// Assumes a single 100 MHz clock domain and 8-bit ASCII command traffic.

package ssl_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int          CLK_HZ    = 100_000_000;
    localparam int          BAUD_RATE = 19200;
    // Whole cycles per bit, rounded down (5208 at 100 MHz)
    localparam int          BIT_CYC   = CLK_HZ / BAUD_RATE;
    localparam int          CNT_W     = 16;
    localparam int          SYNC_N    = 2;

    // ************************************************************
    // Frame and channel layout
    // ************************************************************
    localparam int          DATA_BITS = 8;
    localparam int          STOP_IDX  = 9;
    localparam logic [9:0]  CHAN_MAX  = 10'h080;
    localparam int          UNIT_LSB  = 3;
    localparam int          VAL_W     = 10;
    localparam logic [1:0]  MAX_DIG   = 2'h3;
    localparam logic [4:0]  ADDR_MAX  = 5'h0F;
    localparam logic [3:0]  REPLY_LEN = 4'h8;
    localparam logic [2:0]  IDN_LEN   = 3'h5;
    localparam logic [2:0]  RST_LEN   = 3'h3;

    // ************************************************************
    // Characters
    // ************************************************************
    localparam logic [7:0]  CH_NL     = 8'h0A;
    localparam logic [7:0]  CH_STAR   = 8'h2A;
    localparam logic [7:0]  CH_MINUS  = 8'h2D;
    localparam logic [7:0]  CH_COMMA  = 8'h2C;
    localparam logic [7:0]  CH_ZERO   = 8'h30;
    localparam logic [7:0]  CH_NINE   = 8'h39;
    localparam logic [7:0]  CH_CASE   = 8'h20;
    localparam logic [7:0]  CH_A      = 8'h61;
    localparam logic [7:0]  CH_B      = 8'h62;
    localparam logic [7:0]  CH_I      = 8'h69;
    localparam logic [7:0]  CH_O      = 8'h6F;
    // Identity reply fields; values are arbitrary
    localparam logic [7:0]  ID_FW     = 8'h31;
    localparam logic [7:0]  ID_HW     = 8'h31;

    // ************************************************************
    // Parser states
    // ************************************************************
    typedef enum logic [2:0] {
        P_FIRST = 3'b000,
        P_BUS   = 3'b001,
        P_SIGN  = 3'b010,
        P_VAL   = 3'b011,
        P_ADDR  = 3'b100,
        P_MATCH = 3'b101,
        P_SKIP  = 3'b110
    } ssl_pst_t;

endpackage : ssl_pkg

/* File: logic/ssl_uart.sv */
// Eight-bit asynchronous receiver and transmitter, no parity, one stop bit.
// Assumes i_rxd is already synchronised to i_clk.
`timescale 1ns/1ps

module ssl_uart #(
    parameter logic [15:0] BIT_CYCLES = 16'(ssl_pkg::BIT_CYC)
) (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // Receive side
    input  wire logic       i_rxd,
    output logic      [7:0] o_rx_data,
    output logic            o_rx_valid,
    // Transmit side
    input  wire logic       i_tx_start,
    input  wire logic [7:0] i_tx_data,
    output logic            o_tx_busy,
    output logic            o_txd
);

    logic                 rx_act_reg;
    logic [15:0]          rx_cnt_reg;
    logic [3:0]           rx_bit_reg;
    logic [7:0]           rx_sh_reg;
    logic                 tx_act_reg;
    logic [15:0]          tx_cnt_reg;
    logic [3:0]           tx_bit_reg;
    logic [9:0]           tx_sh_reg;
    logic                 tx_line_reg;

    // ************************************************************
    // Receiver
    // ************************************************************
    // Start edge, mid-bit sampling, LSB first
    always_ff @(posedge i_clk) begin
        o_rx_valid <= 1'b0;
        if (!i_rst_n) begin
            rx_act_reg <= 1'b0;
            rx_cnt_reg <= 16'h0000;
            rx_bit_reg <= 4'h0;
            rx_sh_reg  <= 8'h00;
            o_rx_data  <= 8'h00;
        end else if (!rx_act_reg) begin
            if (!i_rxd) begin
                rx_act_reg <= 1'b1;
                rx_cnt_reg <= BIT_CYCLES >> 1;
                rx_bit_reg <= 4'h0;
            end
        end else if (rx_cnt_reg != 16'h0000) begin
            rx_cnt_reg <= rx_cnt_reg - 16'h0001;
        end else begin
            rx_cnt_reg <= BIT_CYCLES - 16'h0001;
            if (rx_bit_reg == 4'h0) begin
                // A glitch shorter than half a bit is not a start bit
                rx_act_reg <= ~i_rxd;
                rx_bit_reg <= 4'h1;
            end else if (rx_bit_reg < 4'(ssl_pkg::STOP_IDX)) begin
                rx_sh_reg  <= {i_rxd, rx_sh_reg[7:1]};
                rx_bit_reg <= rx_bit_reg + 4'h1;
            end else begin
                // Framing errors drop the character silently
                rx_act_reg <= 1'b0;
                o_rx_valid <= i_rxd;
                o_rx_data  <= i_rxd ? rx_sh_reg : o_rx_data;
            end
        end
    end

    // ************************************************************
    // Transmitter
    // ************************************************************
    // Start bit, data LSB first, stop bit
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tx_act_reg  <= 1'b0;
            tx_cnt_reg  <= 16'h0000;
            tx_bit_reg  <= 4'h0;
            tx_sh_reg   <= 10'h3FF;
            tx_line_reg <= 1'b1;
        end else if (!tx_act_reg) begin
            tx_line_reg <= 1'b1;
            if (i_tx_start) begin
                tx_act_reg <= 1'b1;
                tx_sh_reg  <= {1'b1, i_tx_data, 1'b0};
                tx_cnt_reg <= BIT_CYCLES - 16'h0001;
                tx_bit_reg <= 4'h0;
            end
        end else begin
            tx_line_reg <= tx_sh_reg[0];
            if (tx_cnt_reg != 16'h0000) begin
                tx_cnt_reg <= tx_cnt_reg - 16'h0001;
            end else begin
                tx_cnt_reg <= BIT_CYCLES - 16'h0001;
                tx_sh_reg  <= {1'b1, tx_sh_reg[9:1]};
                tx_bit_reg <= tx_bit_reg + 4'h1;
                tx_act_reg <= (tx_bit_reg != 4'(ssl_pkg::STOP_IDX));
            end
        end
    end

    assign o_tx_busy = tx_act_reg;
    assign o_txd     = tx_line_reg;

endmodule : ssl_uart

/* File: logic/ssl_switcher_link.sv */
// Serial control link of one relay-matrix switcher unit in a cascade.
// Assumes pins are asynchronous and that the controller sends one command at a time.
//
// Functional notes
// - Asynchronous serial framing, no shared clock.
// - Fixed 19200 baud on both ends.
// - Two data lines, transfers strictly sequential.
// - Only one unit drives return path.
// - Command traffic not gated by flow control.
// - Ready output high when operational.
// - Request-to-send shows receive readiness.
// - Commands arrive on receive-data input.
// - Replies leave on transmit-data output.
// - Upstream port in, downstream port forwards.
// - Incompatible command rejected, state unchanged.
// - Output type, busbar B -1: all except A.
// - Input and output types share addresses.
// - Start, eight data LSB first, one stop.
// - Setting command opens old channel everywhere.
`timescale 1ns/1ps

module ssl_switcher_link #(
    // Cycles per bit at the fixed link rate; shorten in simulation
    parameter logic [15:0] BIT_CYCLES = 16'(ssl_pkg::BIT_CYC)
) (
    // Clock and reset
    input  wire logic       I_MCLK,
    input  wire logic       I_RST_N,
    // Upstream port towards the controller
    input  wire logic       I_RXD,
    output logic            O_TXD,
    output logic            O_DSR,
    output logic            O_RTS,
    input  wire logic       I_CTS,
    // Downstream port towards the next unit
    output logic            O_DS_TXD,
    input  wire logic       I_DS_RXD,
    output logic            O_DS_CTS,
    // Straps: coding switch and unit type
    input  wire logic [3:0] I_ADDR,
    input  wire logic       I_OUT_TYPE,
    // Relay drives, one bit per local channel
    output logic      [7:0] O_RELAY_A,
    output logic      [7:0] O_RELAY_B
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [7:0] fold(input logic [7:0] c);
        fold = c | ssl_pkg::CH_CASE;
    endfunction : fold

    function automatic logic is_dig(input logic [7:0] c);
        is_dig = (c >= ssl_pkg::CH_ZERO) && (c <= ssl_pkg::CH_NINE);
    endfunction : is_dig

    function automatic logic [9:0] acc10(input logic [9:0] v, input logic [7:0] c);
        logic [13:0] t;
        t     = 14'(v) * 14'h000A + 14'(c - ssl_pkg::CH_ZERO);
        acc10 = t[9:0];
    endfunction : acc10

    // Expected character at idx of "*idn?" (rst=0) or "RST" (rst=1)
    function automatic logic [7:0] pattern(input logic rst, input logic [2:0] idx);
        logic [39:0] s;
        s       = rst ? 40'h5253540000 : 40'h2A69646E3F;
        pattern = s[8'(39 - 8 * idx) -: 8];
    endfunction : pattern

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [ssl_pkg::SYNC_N-1:0] rxd_sy_reg;
    logic [ssl_pkg::SYNC_N-1:0] cts_sy_reg;
    logic [ssl_pkg::SYNC_N-1:0] dsr_sy_reg;
    logic [3:0]           addr_m_reg;
    logic [3:0]           addr_s_reg;
    logic                 otyp_m_reg;
    logic                 otyp_s_reg;
    logic                 rxd_s;
    logic                 cts_s;
    logic                 ds_rxd_s;
    logic [7:0]           rx_data;
    logic                 rx_valid;
    logic                 utx_busy;
    logic                 utxd;
    ssl_pkg::ssl_pst_t    pst_reg;
    ssl_pkg::ssl_pst_t    pst_next;
    logic                 ctyp_reg;
    logic                 cbus_b_reg;
    logic                 neg_reg;
    logic [9:0]           val_reg;
    logic [1:0]           ndig_reg;
    logic                 mrst_reg;
    logic [2:0]           midx_reg;
    logic [7:0]           ra_reg;
    logic [7:0]           rb_reg;
    logic                 ball_reg;
    logic [7:0]           relay_b_reg;
    logic                 ready_reg;
    logic                 tx_act_reg;
    logic [3:0]           tx_idx_reg;
    logic                 txd_reg;
    logic                 ds_txd_reg;
    logic                 ds_cts_reg;
    logic                 tx_start;
    logic [7:0]           tx_char;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    // Two flops before any logic looks at a pin
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            rxd_sy_reg <= 2'b11;
            cts_sy_reg <= 2'b00;
            dsr_sy_reg <= 2'b11;
            addr_m_reg <= 4'h0;
            addr_s_reg <= 4'h0;
            otyp_m_reg <= 1'b0;
            otyp_s_reg <= 1'b0;
        end else begin
            rxd_sy_reg <= {rxd_sy_reg[0], I_RXD};
            cts_sy_reg <= {cts_sy_reg[0], I_CTS};
            dsr_sy_reg <= {dsr_sy_reg[0], I_DS_RXD};
            addr_m_reg <= I_ADDR;
            addr_s_reg <= addr_m_reg;
            otyp_m_reg <= I_OUT_TYPE;
            otyp_s_reg <= otyp_m_reg;
        end
    end

    assign rxd_s    = rxd_sy_reg[1];
    assign cts_s    = cts_sy_reg[1];
    assign ds_rxd_s = dsr_sy_reg[1];

    // ************************************************************
    // Character engine
    // ************************************************************
    ssl_uart #(
        .BIT_CYCLES (BIT_CYCLES)
    ) u_uart (
        .i_clk      (I_MCLK),
        .i_rst_n    (I_RST_N),
        .i_rxd      (rxd_s),
        .o_rx_data  (rx_data),
        .o_rx_valid (rx_valid),
        .i_tx_start (tx_start),
        .i_tx_data  (tx_char),
        .o_tx_busy  (utx_busy),
        .o_txd      (utxd)
    );

    // ************************************************************
    // Character classification
    // ************************************************************
    // Commands are parsed regardless of any handshake line
    wire       c_nl     = rx_data == ssl_pkg::CH_NL;
    wire [7:0] c_low    = fold(rx_data);
    wire       c_typ    = (c_low == ssl_pkg::CH_I) || (c_low == ssl_pkg::CH_O);
    wire       c_bus    = (c_low == ssl_pkg::CH_A) || (c_low == ssl_pkg::CH_B);
    wire       c_dig    = is_dig(rx_data);
    wire [9:0] val_acc  = acc10(val_reg, rx_data);
    wire       m_hit    = rx_data == pattern(mrst_reg, midx_reg);
    wire [2:0] m_len    = mrst_reg ? ssl_pkg::RST_LEN : ssl_pkg::IDN_LEN;

    // ************************************************************
    // Parser next state
    // ************************************************************
    always_comb begin
        pst_next = pst_reg;
        unique case (pst_reg)
            ssl_pkg::P_FIRST: begin
                if (c_low == ssl_pkg::CH_A)
                    pst_next = ssl_pkg::P_ADDR;
                else if (c_typ)
                    pst_next = ssl_pkg::P_BUS;
                else if (rx_data == ssl_pkg::CH_STAR)
                    pst_next = ssl_pkg::P_MATCH;
                else
                    pst_next = ssl_pkg::P_SKIP;
            end
            ssl_pkg::P_BUS:   pst_next = c_bus ? ssl_pkg::P_SIGN : ssl_pkg::P_SKIP;
            ssl_pkg::P_SIGN: begin
                if (rx_data == ssl_pkg::CH_MINUS || c_dig)
                    pst_next = ssl_pkg::P_VAL;
                else
                    pst_next = ssl_pkg::P_SKIP;
            end
            ssl_pkg::P_VAL: begin
                if (!c_dig || ndig_reg == ssl_pkg::MAX_DIG)
                    pst_next = ssl_pkg::P_SKIP;
            end
            ssl_pkg::P_ADDR: begin
                if (c_typ && ndig_reg != 2'h0)
                    pst_next = ssl_pkg::P_MATCH;
                else if (!c_dig || val_acc > 10'(ssl_pkg::ADDR_MAX))
                    pst_next = ssl_pkg::P_SKIP;
            end
            ssl_pkg::P_MATCH: begin
                if (midx_reg == m_len || !m_hit)
                    pst_next = ssl_pkg::P_SKIP;
            end
            ssl_pkg::P_SKIP:  pst_next = ssl_pkg::P_SKIP;
            default:          pst_next = ssl_pkg::P_SKIP;
        endcase
        if (c_nl)
            pst_next = ssl_pkg::P_FIRST;
    end

    // ************************************************************
    // Command decode at end of line
    // ************************************************************
    // Own type only; the other type at the same address ignores it
    wire       own_typ  = ctyp_reg == otyp_s_reg;
    wire       at_end   = rx_valid && c_nl;
    wire       set_ok   = at_end && pst_reg == ssl_pkg::P_VAL && ndig_reg != 2'h0;
    wire       is_minus = neg_reg && val_reg == 10'h001;
    // Only busbar B of an output unit accepts -1
    wire       neg_ok   = is_minus && ctyp_reg && cbus_b_reg;
    wire       do_set   = set_ok && own_typ && (!neg_reg || neg_ok);
    wire       m_done   = at_end && pst_reg == ssl_pkg::P_MATCH && midx_reg == m_len;
    wire       do_rst   = m_done && mrst_reg;
    wire       do_idn   = m_done && !mrst_reg && own_typ && val_reg[3:0] == addr_s_reg;
    wire [9:0] ch_m1    = val_reg - 10'h001;
    wire       in_range = val_reg != 10'h000 && val_reg <= ssl_pkg::CHAN_MAX;
    // Channel n lives on unit (n-1)/8, relay (n-1)%8
    wire       hit      = in_range && ch_m1[6:ssl_pkg::UNIT_LSB] == addr_s_reg;
    wire [7:0] onehot   = hit ? 8'h01 << ch_m1[2:0] : 8'h00;

    // ************************************************************
    // Parser registers
    // ************************************************************
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            pst_reg    <= ssl_pkg::P_FIRST;
            ctyp_reg   <= 1'b0;
            cbus_b_reg <= 1'b0;
            neg_reg    <= 1'b0;
            val_reg    <= 10'h000;
            ndig_reg   <= 2'h0;
            mrst_reg   <= 1'b0;
            midx_reg   <= 3'h0;
        end else if (rx_valid) begin
            pst_reg <= pst_next;
            if (pst_reg == ssl_pkg::P_FIRST) begin
                ctyp_reg <= c_low == ssl_pkg::CH_O;
                mrst_reg <= rx_data == ssl_pkg::CH_STAR;
                midx_reg <= 3'h0;
                neg_reg  <= 1'b0;
                val_reg  <= 10'h000;
                ndig_reg <= 2'h0;
            end
            if (pst_reg == ssl_pkg::P_BUS)
                cbus_b_reg <= c_low == ssl_pkg::CH_B;
            if (pst_reg == ssl_pkg::P_SIGN && rx_data == ssl_pkg::CH_MINUS)
                neg_reg <= 1'b1;
            // Digits of a channel number or of an address
            if ((pst_reg == ssl_pkg::P_SIGN || pst_reg == ssl_pkg::P_VAL
                    || pst_reg == ssl_pkg::P_ADDR) && c_dig && ndig_reg != ssl_pkg::MAX_DIG) begin
                val_reg  <= val_acc;
                ndig_reg <= ndig_reg + 2'h1;
            end
            if (pst_reg == ssl_pkg::P_ADDR && c_typ)
                ctyp_reg <= c_low == ssl_pkg::CH_O;
            if (pst_reg == ssl_pkg::P_MATCH)
                midx_reg <= midx_reg + 3'h1;
        end
    end

    // ************************************************************
    // Relay state
    // ************************************************************
    // Unknown or incompatible lines leave every relay alone
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            ra_reg   <= 8'h00;
            rb_reg   <= 8'h00;
            ball_reg <= 1'b0;
        end else if (do_rst) begin
            ra_reg   <= 8'h00;
            rb_reg   <= 8'h00;
            ball_reg <= 1'b0;
        end else if (do_set && neg_ok) begin
            rb_reg   <= 8'h00;
            ball_reg <= 1'b1;
        end else if (do_set && !cbus_b_reg) begin
            // Old channel opens on every unit, new one closes here only
            ra_reg <= onehot;
            rb_reg <= rb_reg & ~onehot;             // Same channel leaves the other bus
        end else if (do_set) begin
            rb_reg   <= onehot;
            ball_reg <= 1'b0;
            ra_reg   <= ra_reg & ~onehot;
        end
    end

    // Busbar B in -1 mode is the inverse of busbar A, continuously
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N)
            relay_b_reg <= 8'h00;
        else
            relay_b_reg <= ball_reg ? ~ra_reg : rb_reg;
    end

    // ************************************************************
    // Identity reply
    // ************************************************************
    wire [3:0] tx_idx = tx_idx_reg;
    assign tx_char =
        (tx_idx == 4'h0) ? 8'h53 :
        (tx_idx == 4'h1) ? 8'h57 :
        (tx_idx == 4'h2) ? 8'h4C :
        (tx_idx == 4'h4) ? ssl_pkg::ID_FW :
        (tx_idx == 4'h6) ? ssl_pkg::ID_HW :
        (tx_idx == 4'h7) ? ssl_pkg::CH_NL : ssl_pkg::CH_COMMA;
    // Each character waits for clear-to-send
    assign tx_start = tx_act_reg && !utx_busy && cts_s && tx_idx_reg != ssl_pkg::REPLY_LEN;

    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            tx_act_reg <= 1'b0;
            tx_idx_reg <= 4'h0;
        end else if (!tx_act_reg) begin
            tx_act_reg <= do_idn;
            tx_idx_reg <= 4'h0;
        end else if (tx_start) begin
            tx_idx_reg <= tx_idx_reg + 4'h1;
        end else if (tx_idx_reg == ssl_pkg::REPLY_LEN && !utx_busy) begin
            tx_act_reg <= 1'b0;
        end
    end

    // ************************************************************
    // Port drivers
    // ************************************************************
    // Downstream replies are muted while this unit answers, so two
    // units never overlap on the return line
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            ready_reg  <= 1'b0;
            txd_reg    <= 1'b1;
            ds_txd_reg <= 1'b1;
            ds_cts_reg <= 1'b0;
        end else begin
            ready_reg  <= 1'b1;
            txd_reg    <= tx_act_reg ? utxd : ds_rxd_s;
            ds_txd_reg <= rxd_s;
            ds_cts_reg <= cts_s && !tx_act_reg;
        end
    end

    assign O_DSR     = ready_reg;
    assign O_RTS     = ready_reg && !tx_act_reg;
    assign O_TXD     = txd_reg;
    assign O_DS_TXD  = ds_txd_reg;
    assign O_DS_CTS  = ds_cts_reg;
    assign O_RELAY_A = ra_reg;
    assign O_RELAY_B = relay_b_reg;

endmodule : ssl_switcher_link

/* File: dv/ssl_link_chk_properties.sv */
// Concurrent checks on the ports of the switcher serial link.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps

module ssl_link_chk (
    input wire logic       I_MCLK, I_RST_N, I_RXD, O_TXD, O_DSR, O_RTS,
    input wire logic       I_CTS, O_DS_TXD, I_DS_RXD, O_DS_CTS,
    input wire logic [7:0] O_RELAY_A, O_RELAY_B
);
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_N);
    // Reply start and the quiet stretch of a reply
    sequence s_start; ##[0:8] !O_TXD; endsequence
    sequence s_quiet; !O_RTS [*2]; endsequence
    property p_dsr; $past(I_RST_N) |-> O_DSR; endproperty
    property p_ds_txd; $past(I_RST_N, 4) |-> O_DS_TXD == $past(I_RXD, 3); endproperty
    property p_echo; O_RTS && $past(O_RTS, 4) |-> O_TXD == $past(I_DS_RXD, 3); endproperty
    property p_dscts; s_quiet |-> !O_DS_CTS; endproperty
    // B lags A by one cycle, so pair B with the A of the cycle before
    property p_excl; ($past(O_RELAY_A) & O_RELAY_B) == 8'h00; endproperty
    property p_cause; $changed(O_RELAY_A) |-> $past(I_RXD, 3); endproperty
    property p_reply; $fell(O_RTS) && I_CTS && $past(I_CTS, 3) |-> s_start; endproperty
    property p_hold; $fell(O_RTS) |=> !O_RTS [*8]; endproperty
    a_dsr: assert property (p_dsr) else $error("ready low after reset");
    a_ds_txd: assert property (p_ds_txd) else $error("downstream copy wrong");
    a_echo: assert property (p_echo) else $error("return path not echoed");
    a_dscts: assert property (p_dscts) else $error("downstream allowed in reply");
    a_excl: assert property (p_excl) else $error("channel on both busbars");
    a_cause: assert property (p_cause) else $error("relay change off stop bit");
    a_reply: assert property (p_reply) else $error("reply did not start");
    a_hold: assert property (p_hold) else $error("receive ready during reply");
endmodule : ssl_link_chk

bind ssl_switcher_link ssl_link_chk ssl_link_chk_inst (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N),
    .I_RXD(I_RXD), .O_TXD(O_TXD), .O_DSR(O_DSR), .O_RTS(O_RTS), .I_CTS(I_CTS),
    .O_DS_TXD(O_DS_TXD), .I_DS_RXD(I_DS_RXD), .O_DS_CTS(O_DS_CTS),
    .O_RELAY_A(O_RELAY_A), .O_RELAY_B(O_RELAY_B));

/* File: dv/ssl_peer_model.sv */
// Controller and downstream unit: drives the command and reply lines.
// Assumes a bit time of 16 cycles; lines idle at the mark level.
`timescale 1ns/1ps

module ssl_peer_model (
    input  wire logic i_clk,
    output logic      o_rxd,
    output logic      o_ds_rxd
);
    initial begin
        o_rxd = 1'b1;
        o_ds_rxd = 1'b1;
    end
    // Start, eight bits low first, stop; no clock line at all
    task frame(input logic ds, input logic [7:0] c);
        logic [9:0] f;
        f = {1'b1, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge i_clk);
            if (ds) o_ds_rxd = f[i];
            else o_rxd = f[i];
            repeat (15) @(negedge i_clk);
        end
    endtask : frame
    // Characters go one after another, no flow control between them
    task send(input string s);
        for (int i = 0; i < s.len(); i++) frame(1'b0, s[i]);
    endtask : send
endmodule : ssl_peer_model

/* File: dv/ssl_switcher_link_test.sv */
// Self-checking bench for one switcher unit at address 0.
// Assumes the peer model and the bound checker; bit time shortened to 16.
`timescale 1ns/1ps

module ssl_switcher_link_test;
    logic clk = 0, rst_n = 0, cts = 1, otype = 0, h;
    logic [7:0] d, ra, rb;
    wire rxd, dsrx, txd, dsr, rts, dstxd, dscts;
    int fails = 0, checked = 0;
    string nm;
    // Command, then {unit type, busbar A, busbar B} after it
    string cmds[16] = '{"ia5\n", "ib6\n", "ib5\n", "IA2\n", "ia129\n", "ia7\n", "ia9\n",
        "oa3\n", "ib-1\n", "ib0\n", "ia3\n", "*RST\n", "oa3\n", "ob-1\n", "oa4\n", "ob-2\n"};
    logic [16:0] exps[16] = '{17'h01000, 17'h01020, 17'h00010, 17'h00210, 17'h00010,
        17'h04010, 17'h00010, 17'h00010, 17'h00010, 17'h00000, 17'h00400, 17'h00000,
        17'h10400, 17'h104FB, 17'h108F7, 17'h108F7};
    always #5 clk = ~clk;
    ssl_peer_model ssl_peer_model_inst (.i_clk(clk), .o_rxd(rxd), .o_ds_rxd(dsrx));
    ssl_switcher_link #(.BIT_CYCLES(16'h0010)) ssl_switcher_link_inst (.I_MCLK(clk),
        .I_RST_N(rst_n), .I_RXD(rxd), .O_TXD(txd), .O_DSR(dsr), .O_RTS(rts), .I_CTS(cts),
        .O_DS_TXD(dstxd), .I_DS_RXD(dsrx), .O_DS_CTS(dscts), .I_ADDR(4'h0),
        .I_OUT_TYPE(otype), .O_RELAY_A(ra), .O_RELAY_B(rb));
    task cmp(input string n, input logic [15:0] e, input logic [15:0] s);
        checked++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : cmp
    task complete_run;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    // Bounded wait for a start bit, then sample mid-bit
    task rx(output logic [7:0] b);
        int n;
        n = 0;
        while (txd !== 1'b0 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        repeat (8) @(negedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(negedge clk);
            b[i] = txd;
        end
        repeat (16) @(negedge clk);
    endtask : rx
    task reply;
        logic [63:0] e;
        e = {8'h53, 8'h57, 8'h4C, 8'h2C, ssl_pkg::ID_FW, 8'h2C, ssl_pkg::ID_HW, 8'h0A};
        for (int k = 7; k >= 0; k--) begin
            rx(d);
            cmp("reply", {8'h00, e[8*k+:8]}, {8'h00, d});
        end
        repeat (16) @(negedge clk);
        cmp("rts", 16'h0001, {15'h0, rts});
    endtask : reply
    // Watchdog well beyond the expected seventeen thousand cycles
    initial begin
        repeat (60000) @(negedge clk);
        fails++;
        complete_run();
    end
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1;
        repeat (4) @(negedge clk);
        cmp("dsr", 16'h0001, {15'h0, dsr});
        cmp("rts", 16'h0001, {15'h0, rts});
        for (int i = 0; i < 16; i++) begin
            otype = exps[i][16];
            repeat (4) @(negedge clk);
            ssl_peer_model_inst.send(cmds[i]);
            nm = cmds[i].substr(0, cmds[i].len() - 2);
            repeat (6) @(negedge clk);
            cmp(nm, exps[i][15:0], {ra, rb});
            $display("test %s done", nm);
        end
        // Query with transmit allowed at once
        fork
            ssl_peer_model_inst.send("a0o*idn?\n");
            reply();
        join
        $display("test query done");
        // Transmit withheld, then allowed
        cts = 0;
        h = 1;
        ssl_peer_model_inst.send("a0O*idn?\n");
        repeat (40) begin
            @(negedge clk);
            h &= txd;
        end
        cmp("held", 16'h0001, {15'h0, h});
        cts = 1;
        fork
            reply();
            begin
                repeat (60) @(negedge clk);
                cmp("dscts", 16'h0000, {15'h0, dscts});
            end
        join
        $display("test withheld query done");
        // A downstream reply reaches the controller unchanged
        fork
            ssl_peer_model_inst.frame(1'b1, 8'hA5);
            rx(d);
        join
        cmp("echo", 16'h00A5, {8'h00, d});
        cmp("dscts", 16'h0001, {15'h0, dscts});
        $display("test echo done");
        // Reset in mid-run clears relays and ready
        rst_n = 0;
        repeat (3) @(negedge clk);
        cmp("relays", 16'h0000, {ra, rb});
        cmp("dsr", 16'h0000, {15'h0, dsr});
        rst_n = 1;
        repeat (2) @(negedge clk);
        cmp("dsr", 16'h0001, {15'h0, dsr});
        cmp("rts", 16'h0001, {15'h0, rts});
        $display("test reset done");
        complete_run();
    end
endmodule : ssl_switcher_link_test
